// [rtl/flash_cmd_pkg.sv]
// Constants for the flash command sequencer: register map, status bits,
// command codes, parameter indices and array geometry.
// Assumes a 32-bit APB bus and a 24-bit global flash address space.
package flash_cmd_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_STATUS = 12'h000;
	localparam logic [11:0] OFF_INDEX = 12'h004;
	localparam logic [11:0] OFF_PARAM = 12'h008;
	localparam logic [11:0] OFF_PROT = 12'h00C;
	localparam logic [11:0] OFF_MODE = 12'h010;
	// Status register bit positions
	localparam int BIT_CMD_COMPLETE_FLAG = 7;
	localparam int BIT_ACCESS_ERROR_FLAG = 5;
	localparam int BIT_PROTECT_VIOLATION_FLAG = 4;
	localparam int BIT_MG_HI = 1;
	localparam int BIT_MG_LO = 0;
	// Protection register: enable bit and start address field
	localparam int BIT_PROT_EN = 31;
	// Command codes
	localparam logic [7:0] CMD_EVS = 8'h03;
	localparam logic [7:0] CMD_RO = 8'h04;
	localparam logic [7:0] CMD_PGM = 8'h06;
	localparam logic [7:0] CMD_PO = 8'h07;
	// Mode mask bit per command (1 = not permitted)
	localparam int MB_EVS = 0;
	localparam int MB_RO = 1;
	localparam int MB_PGM = 2;
	localparam int MB_PO = 3;
	// Parameter indices
	localparam logic [2:0] IDX_CMD = 3'h0;
	localparam logic [2:0] IDX_ADDR = 3'h1;
	localparam logic [2:0] IDX_CNT = 3'h2;
	localparam logic [2:0] IDX_LW0 = 3'h3;
	localparam logic [2:0] IDX_LW1 = 3'h5;
	localparam int NUM_PARAM = 6;
	// Geometry
	localparam logic [24:0] FLASH_SIZE = 25'h0004000;
	localparam logic [15:0] PHRASE_MAX = 16'h0007;
	localparam logic [31:0] ERASED_LW = 32'hFFFFFFFF;
	localparam logic [15:0] PHRASE_LWS = 16'h0002;
	// Reset values
	localparam logic [31:0] PROT_RST = 32'h00000000;
	localparam logic [3:0] MODE_RST = 4'h0;
	// Engine states
	typedef enum logic [2:0] {ST_IDLE, ST_BLANK, ST_WRITE, ST_VERIFY, ST_FETCH} state_t;
endpackage

// [rtl/flash_cmd_seq.sv]
// Flash command sequencer: erase-verify section, read-once, program, program-once.
// Assumes an APB master on the register side and a flash array that answers
// each held request with a one-cycle ack, read data and a read-error flag.
`timescale 1ns/1ps

module flash_cmd_seq
	import flash_cmd_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flash array
	output logic fl_req,
	output logic fl_we,
	output logic fl_info,
	output logic [23:0] fl_addr,
	output logic [31:0] fl_wdata,
	input wire logic fl_ack,
	input wire logic [31:0] fl_rdata,
	input wire logic fl_err,
	// Read-path poisoning while the info field is in use
	output logic rd_invalid
);

	logic cmd_complete_flag_q, cmd_complete_flag_d;
	logic access_error_flag_q, access_error_flag_d;
	logic protect_violation_flag_q, protect_violation_flag_d;
	logic [1:0] verify_fail_bits_q, verify_fail_bits_d;
	logic [2:0] param_index_q, param_index_d;
	logic [15:0] cmd_param_regs_q [NUM_PARAM];
	logic [15:0] cmd_param_regs_d [NUM_PARAM];
	logic [31:0] prot_q, prot_d;
	logic [3:0] mode_q, mode_d;
	logic [31:0] prdata_q, prdata_d;
	state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] num_q, num_d;
	logic [23:0] base_q, base_d;
	logic info_q, info_d;
	logic [23:0] fl_addr_q, fl_addr_d;
	logic [31:0] fl_wdata_q, fl_wdata_d;
	logic wr_en, setup, go, lerr, perr, mapped;
	logic [7:0] cmd;
	logic [23:0] gaddr;
	logic [15:0] phrase;
	logic [31:0] expect_lw;

	// Longword k of the program data, high word first
	function automatic logic [31:0] data_lw(input logic [15:0] p [NUM_PARAM],
			input logic [15:0] k);
		data_lw = k[0] ? {p[4], p[5]} : {p[2], p[3]};
	endfunction

	// True when [a, a+len) runs past the end of the array
	function automatic logic past_end(input logic [23:0] a, input logic [17:0] len);
		past_end = ({1'b0, a} + {7'h00, len}) > FLASH_SIZE;
	endfunction

	// Decoded fields of the loaded command
	assign cmd = cmd_param_regs_q[0][15:8];
	assign gaddr = {cmd_param_regs_q[0][7:0], cmd_param_regs_q[1]};
	assign phrase = cmd_param_regs_q[1];
	assign expect_lw = (state_q == ST_BLANK) ? ERASED_LW : data_lw(cmd_param_regs_q, cnt_q);
	assign wr_en = psel && penable && pwrite;
	assign setup = psel && !penable;
	assign mapped = (paddr == OFF_STATUS) || (paddr == OFF_INDEX) || (paddr == OFF_PARAM) ||
		(paddr == OFF_PROT) || (paddr == OFF_MODE);
	// Launch: write 1 to the complete flag while idle and error flags clear
	assign go = wr_en && (paddr == OFF_STATUS) && pwdata[BIT_CMD_COMPLETE_FLAG] && cmd_complete_flag_q &&
		!access_error_flag_q && !protect_violation_flag_q;

	// Launch-time parameter checks
	always_comb begin
		lerr = 1'b0;
		perr = 1'b0;
		unique case (cmd)
			CMD_EVS: lerr = (param_index_q != IDX_CNT) || mode_q[MB_EVS] ||
				({1'b0, gaddr} >= FLASH_SIZE) || (gaddr[1:0] != 2'b00) ||
				past_end(gaddr, {cmd_param_regs_q[2], 2'b00});
			CMD_RO: lerr = (param_index_q != IDX_ADDR) || mode_q[MB_RO] ||
				(phrase > PHRASE_MAX);
			CMD_PGM: begin
				lerr = !((param_index_q == IDX_LW0) || (param_index_q == IDX_LW1)) ||
					mode_q[MB_PGM] || ({1'b0, gaddr} >= FLASH_SIZE) ||
					(gaddr[1:0] != 2'b00) ||
					past_end(gaddr, (param_index_q == IDX_LW1) ? 18'h00008 : 18'h00004);
				// Protected region runs from the start address to the array end
				perr = prot_q[BIT_PROT_EN] && ({1'b0, gaddr} +
					((param_index_q == IDX_LW1) ? 25'h0000008 : 25'h0000004) >
					{1'b0, prot_q[23:0]});
			end
			CMD_PO: lerr = (param_index_q != IDX_LW1) || mode_q[MB_PO] ||
				(phrase > PHRASE_MAX);
			default: lerr = 1'b1;
		endcase
	end

	// Register writes, launch and the command engine
	always_comb begin
		cmd_complete_flag_d = cmd_complete_flag_q;
		access_error_flag_d = access_error_flag_q;
		protect_violation_flag_d = protect_violation_flag_q;
		verify_fail_bits_d = verify_fail_bits_q;
		param_index_d = param_index_q;
		cmd_param_regs_d = cmd_param_regs_q;
		prot_d = prot_q;
		mode_d = mode_q;
		state_d = state_q;
		cnt_d = cnt_q;
		num_d = num_q;
		base_d = base_q;
		info_d = info_q;
		// Register writes; parameters are frozen while a command runs
		if (wr_en) begin
			unique case (paddr)
				OFF_STATUS: begin
					if (pwdata[BIT_ACCESS_ERROR_FLAG]) access_error_flag_d = 1'b0;
					if (pwdata[BIT_PROTECT_VIOLATION_FLAG]) protect_violation_flag_d = 1'b0;
				end
				OFF_INDEX: if (cmd_complete_flag_q) param_index_d = pwdata[2:0];
				OFF_PARAM: if (cmd_complete_flag_q && param_index_q < 3'(NUM_PARAM))
					cmd_param_regs_d[param_index_q] = pwdata[15:0];
				OFF_PROT: if (cmd_complete_flag_q) prot_d = pwdata;
				OFF_MODE: if (cmd_complete_flag_q) mode_d = pwdata[3:0];
				default: ;
			endcase
		end
		// Launch: a rejected command never starts
		if (go) begin
			verify_fail_bits_d = 2'b00;
			cnt_d = 16'h0000;
			if (lerr) begin
				access_error_flag_d = 1'b1;
			end else if (perr) begin
				protect_violation_flag_d = 1'b1;
			end else begin
				cmd_complete_flag_d = 1'b0;
				unique case (cmd)
					CMD_EVS: begin
						base_d = gaddr;
						num_d = cmd_param_regs_q[2];
						state_d = (cmd_param_regs_q[2] == 16'h0000) ? ST_IDLE : ST_BLANK;
						cmd_complete_flag_d = (cmd_param_regs_q[2] == 16'h0000);
					end
					CMD_RO: begin
						base_d = {phrase[4:0], 3'b000} + 24'h000000;
						num_d = PHRASE_LWS;
						info_d = 1'b1;
						state_d = ST_FETCH;
					end
					CMD_PGM: begin
						base_d = gaddr;
						num_d = (param_index_q == IDX_LW1) ? 16'h0002 : 16'h0001;
						state_d = ST_WRITE;
					end
					default: begin
						base_d = {phrase[4:0], 3'b000} + 24'h000000;
						num_d = PHRASE_LWS;
						info_d = 1'b1;
						state_d = ST_BLANK;
					end
				endcase
			end
		end
		// One array access completes per ack
		if (state_q != ST_IDLE && fl_ack) begin
			cnt_d = cnt_q + 16'h0001;
			if ((state_q != ST_WRITE) && (fl_err ||
					((state_q != ST_FETCH) && (fl_rdata != expect_lw))))
				verify_fail_bits_d = 2'b11;
			unique case (state_q)
				ST_BLANK: begin
					if (cmd == CMD_PO && fl_rdata != ERASED_LW) begin
						access_error_flag_d = 1'b1;
						verify_fail_bits_d = verify_fail_bits_q;
						state_d = ST_IDLE;
					end else if (cnt_d == num_q) begin
						cnt_d = 16'h0000;
						state_d = (cmd == CMD_PO) ? ST_WRITE : ST_IDLE;
					end
				end
				ST_WRITE: begin
					cnt_d = cnt_q;
					state_d = ST_VERIFY;
				end
				ST_VERIFY: state_d = (cnt_d == num_q) ? ST_IDLE : ST_WRITE;
				default: begin
					cmd_param_regs_d[IDX_CNT + 3'(cnt_q) * 3'd2] = fl_rdata[31:16];
					cmd_param_regs_d[IDX_LW0 + 3'(cnt_q) * 3'd2] = fl_rdata[15:0];
					state_d = (cnt_d == num_q) ? ST_IDLE : ST_FETCH;
				end
			endcase
			if (state_d == ST_IDLE) begin
				cmd_complete_flag_d = 1'b1;
				info_d = 1'b0;
			end
		end
		// Array request fields follow the next step
		fl_addr_d = base_d + {6'h00, cnt_d, 2'b00};
		fl_wdata_d = data_lw(cmd_param_regs_d, cnt_d);
	end

	// APB read data captured in the setup phase
	always_comb begin
		prdata_d = prdata_q;
		if (setup && !pwrite) begin
			unique case (paddr)
				OFF_STATUS: prdata_d = {24'h000000, cmd_complete_flag_q, 1'b0,
					access_error_flag_q, protect_violation_flag_q, 2'b00, verify_fail_bits_q};
				OFF_INDEX: prdata_d = {29'h00000000, param_index_q};
				OFF_PARAM: prdata_d = (param_index_q < 3'(NUM_PARAM)) ?
					{16'h0000, cmd_param_regs_q[param_index_q]} : 32'h00000000;
				OFF_PROT: prdata_d = prot_q;
				OFF_MODE: prdata_d = {28'h0000000, mode_q};
				default: prdata_d = 32'h00000000;
			endcase
		end
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_complete_flag_q <= 1'b1;
			access_error_flag_q <= 1'b0;
			protect_violation_flag_q <= 1'b0;
			verify_fail_bits_q <= 2'b00;
			param_index_q <= 3'h0;
			for (int i = 0; i < NUM_PARAM; i++) begin
				cmd_param_regs_q[i] <= 16'h0000;
			end
			prot_q <= PROT_RST;
			mode_q <= MODE_RST;
			prdata_q <= 32'h00000000;
			state_q <= ST_IDLE;
			cnt_q <= 16'h0000;
			num_q <= 16'h0000;
			base_q <= 24'h000000;
			info_q <= 1'b0;
			fl_addr_q <= 24'h000000;
			fl_wdata_q <= 32'h00000000;
		end else begin
			cmd_complete_flag_q <= cmd_complete_flag_d;
			access_error_flag_q <= access_error_flag_d;
			protect_violation_flag_q <= protect_violation_flag_d;
			verify_fail_bits_q <= verify_fail_bits_d;
			param_index_q <= param_index_d;
			cmd_param_regs_q <= cmd_param_regs_d;
			prot_q <= prot_d;
			mode_q <= mode_d;
			prdata_q <= prdata_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
			num_q <= num_d;
			base_q <= base_d;
			info_q <= info_d;
			fl_addr_q <= fl_addr_d;
			fl_wdata_q <= fl_wdata_d;
		end
	end

	// Outputs
	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign fl_req = (state_q != ST_IDLE);
	assign fl_we = (state_q == ST_WRITE);
	assign fl_info = info_q;
	assign fl_addr = fl_addr_q;
	assign fl_wdata = fl_wdata_q;
	assign rd_invalid = info_q;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	reject_no_run_a: assert property (go && lerr |=> access_error_flag_q &&
		cmd_complete_flag_q && state_q == ST_IDLE) else $error("rejected command ran");
	evs_index_a: assert property (go && cmd == CMD_EVS && param_index_q != IDX_CNT
		|=> access_error_flag_q) else $error("section verify index not rejected");
	ro_index_a: assert property (go && cmd == CMD_RO && param_index_q != IDX_ADDR
		|=> access_error_flag_q) else $error("read-once index not rejected");
	pgm_index_a: assert property (go && cmd == CMD_PGM && param_index_q != IDX_LW0 &&
		param_index_q != IDX_LW1 |=> access_error_flag_q) else $error("program index");
	po_index_a: assert property (go && cmd == CMD_PO && param_index_q != IDX_LW1
		|=> access_error_flag_q) else $error("program-once index not rejected");
	mode_block_a: assert property (go && cmd == CMD_PGM && mode_q[MB_PGM]
		|=> access_error_flag_q && state_q == ST_IDLE) else $error("mode not enforced");
	prot_flag_a: assert property (go && cmd == CMD_PGM && !lerr && perr
		|=> protect_violation_flag_q && cmd_complete_flag_q) else $error("protection missed");
	busy_flag_a: assert property (state_q != ST_IDLE |-> !cmd_complete_flag_q
		) else $error("complete flag set while busy");
	info_poison_a: assert property (state_q != ST_IDLE && (cmd == CMD_RO || cmd == CMD_PO)
		|-> rd_invalid) else $error("reads not poisoned");
	verify_fail_a: assert property (state_q == ST_VERIFY && fl_ack &&
		fl_rdata != expect_lw |=> verify_fail_bits_q == 2'b11) else $error("verify miss");
	done_flag_a: assert property (state_q != ST_IDLE ##1 state_q == ST_IDLE
		|-> cmd_complete_flag_q && !rd_invalid) else $error("completion not flagged");

	evs_done_c: cover property (state_q == ST_BLANK && cmd == CMD_EVS ##[1:40] state_q == ST_IDLE);
	ro_done_c: cover property (state_q == ST_FETCH ##[1:40] state_q == ST_IDLE);
	pgm_two_c: cover property (go && cmd == CMD_PGM && param_index_q == IDX_LW1 && !lerr);
	po_used_c: cover property (state_q == ST_BLANK && cmd == CMD_PO && fl_ack &&
		fl_rdata != ERASED_LW);
endmodule

// [dv/flash_array_model.sv]
// Behavioural flash array: main longwords plus the one-time info field.
// Assumes the sequencer holds each request until a one-cycle ack.
`timescale 1ns/1ps
module flash_array_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Request from the sequencer
	input wire logic req,
	input wire logic we,
	input wire logic info,
	input wire logic [23:0] addr,
	input wire logic [31:0] wdata,
	// Bench controls: extra latency, read errors, read-data bit flip
	input wire logic slow,
	input wire logic rd_err,
	input wire logic flip,
	// Answer
	output logic ack,
	output logic [31:0] rdata,
	output logic err
);
	logic [31:0] mem [0:4095];
	logic [31:0] inf [0:15];
	logic [1:0] wait_q;
	// Whole array starts erased
	initial begin
		foreach (mem[i]) mem[i] = 32'hFFFFFFFF;
		foreach (inf[i]) inf[i] = 32'hFFFFFFFF;
	end
	// One ack per held request; read data scrambled outside the ack cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'h0;
			err <= 1'h0;
			rdata <= 32'h0;
			wait_q <= 2'h0;
		end else begin
			ack <= 1'h0;
			err <= 1'h0;
			rdata <= ~rdata;
			if (req && !ack) begin
				if (slow && wait_q != 2'h3) begin
					wait_q <= wait_q + 2'h1;
				end else begin
					wait_q <= 2'h0;
					ack <= 1'h1;
					err <= rd_err && !we;
					if (we && info) inf[addr[5:2]] <= wdata;
					else if (we) mem[addr[13:2]] <= wdata;
					else rdata <= (info ? inf[addr[5:2]] : mem[addr[13:2]]) ^ {31'h0, flip};
				end
			end
		end
	end
endmodule

// [dv/flash_cmd_seq_bench.sv]
// Self-checking bench for the flash command sequencer over APB.
// Assumes the flash array model in this folder and the package constants.
`timescale 1ns/1ps
module flash_cmd_seq_bench;
	import flash_cmd_pkg::*;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd, fl_wdata, fl_rdata;
	logic pready, pslverr, serr, fl_req, fl_we, fl_info, fl_ack, fl_err, rd_invalid;
	logic slow = 1'h0, rd_err = 1'h0, saw = 1'h0, flip = 1'h0;
	logic [23:0] fl_addr;
	logic [15:0] p [0:5];
	int fail_count = 0, n_tests = 0;
	// Refused commands: command, address, third word, final index
	logic [50:0] errs [0:11] = '{{16'h0300, 16'h0200, 16'h0001, 3'h1},
		{16'h0300, 16'h0202, 16'h0001, 3'h2}, {16'h0300, 16'h3FF8, 16'h0004, 3'h2},
		{16'h0301, 16'h0000, 16'h0001, 3'h2}, {16'h0600, 16'h0300, 16'h1234, 3'h4},
		{16'h0600, 16'h3FFC, 16'h1234, 3'h5}, {16'h0600, 16'h0302, 16'h1234, 3'h3},
		{16'h0700, 16'h0003, 16'h1234, 3'h5}, {16'h0700, 16'h0008, 16'h1234, 3'h5},
		{16'h0700, 16'h0001, 16'h1234, 3'h4}, {16'h0400, 16'h0001, 16'h1234, 3'h2},
		{16'h0400, 16'h0008, 16'h1234, 3'h1}};
	logic [15:0] mcmd [0:3] = '{16'h0300, 16'h0400, 16'h0600, 16'h0700};
	logic [2:0] mlast [0:3] = '{3'h2, 3'h1, 3'h3, 3'h5};
	flash_cmd_seq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fl_req(fl_req), .fl_we(fl_we), .fl_info(fl_info),
		.fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack), .fl_rdata(fl_rdata),
		.fl_err(fl_err), .rd_invalid(rd_invalid));
	flash_array_model model (.clk(pclk), .rst_n(presetn), .req(fl_req), .we(fl_we),
		.info(fl_info), .addr(fl_addr), .wdata(fl_wdata), .slow(slow), .rd_err(rd_err),
		.flip(flip),
		.ack(fl_ack), .rdata(fl_rdata), .err(fl_err));
	// Clock and poisoned-read monitor
	always #25 pclk = ~pclk;
	always @(posedge pclk) if (rd_invalid === 1'h1) saw <= 1'h1;
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// One APB transfer, held until pready is seen
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	// Load parameters, launch, wait for completion, compare status, clear flags
	task run(input logic [2:0] last, input logic [31:0] exp, input string m);
		int n;
		for (int i = 0; i <= last; i++) begin
			apb(1'h1, OFF_INDEX, 32'(i));
			apb(1'h1, OFF_PARAM, {16'h0, p[i]});
		end
		saw <= 1'h0;
		apb(1'h1, OFF_STATUS, 32'h80);
		n = 0;
		do begin
			apb(1'h0, OFF_STATUS, 32'h0);
			n++;
		end while (rd[BIT_CMD_COMPLETE_FLAG] !== 1'h1 && n < 200);
		check(rd, exp, m);
		apb(1'h1, OFF_STATUS, 32'h30);
	endtask
	initial begin
		#1_000_000;
		fail_count++;
		final_report;
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, OFF_STATUS, 32'h0);
		check(rd, 32'h80, "reset status");
		apb(1'h0, 12'h020, 32'h0);
		check(serr, 1'h1, "unmapped error");
		check(rd, 32'h0, "unmapped data");
		slow <= 1'h1;
		p = '{16'h0300, 16'h0200, 16'h0004, 16'h0, 16'h0, 16'h0};
		run(3'h2, 32'h80, "verify erased");
		slow <= 1'h0;
		p = '{16'h0600, 16'h0100, 16'hA1B2, 16'hC3D4, 16'h5E6F, 16'h7081};
		run(3'h5, 32'h80, "program two");
		check(saw, 1'h0, "no poison pgm");
		check(model.mem[64], 32'hA1B2C3D4, "longword 0");
		check(model.mem[65], 32'h5E6F7081, "longword 1");
		p[0:2] = '{16'h0300, 16'h0100, 16'h0002};
		run(3'h2, 32'h83, "verify programmed");
		p[0:1] = '{16'h0600, 16'h0108};
		run(3'h3, 32'h80, "program one");
		p = '{16'h0700, 16'h0003, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
		run(3'h5, 32'h80, "program once");
		check(saw, 1'h1, "poison po");
		p[0] = 16'h0400;
		run(3'h1, 32'h80, "read once");
		check(saw, 1'h1, "poison ro");
		for (int i = 2; i < 6; i++) begin
			apb(1'h1, OFF_INDEX, 32'(i));
			apb(1'h0, OFF_PARAM, 32'h0);
			check(rd, {16'h0, 16'h1111 * 16'(i - 1)}, "phrase word");
		end
		foreach (errs[i]) begin
			p[0:2] = '{errs[i][50:35], errs[i][34:19], errs[i][18:3]};
			run(errs[i][2:0], 32'hA0, "refused");
		end
		check(model.mem[4095], 32'hFFFFFFFF, "refused untouched");
		p[1:2] = '{16'h0000, 16'h0001};
		for (int k = 0; k < 4; k++) begin
			apb(1'h1, OFF_MODE, 32'(1 << k));
			p[0] = mcmd[k];
			run(mlast[k], 32'hA0, "mode");
		end
		apb(1'h1, OFF_MODE, 32'h0);
		apb(1'h1, OFF_PROT, 32'h80002000);
		p[0:1] = '{16'h0600, 16'h2000};
		run(3'h3, 32'h90, "protected");
		apb(1'h1, OFF_PROT, 32'h0);
		rd_err <= 1'h1;
		p[0:2] = '{16'h0300, 16'h0200, 16'h0001};
		run(3'h2, 32'h83, "read error");
		p[0:1] = '{16'h0400, 16'h0003};
		run(3'h1, 32'h83, "ro error");
		p[0:1] = '{16'h0600, 16'h0300};
		run(3'h3, 32'h83, "pgm verify");
		rd_err <= 1'h0;
		// Read-back differs from the written word with no read error
		flip <= 1'h1;
		p[0:3] = '{16'h0600, 16'h0304, 16'h9ABC, 16'hDEF0};
		run(3'h3, 32'h83, "pgm mismatch");
		check(model.mem[193], 32'h9ABCDEF0, "mismatch written");
		flip <= 1'h0;
		final_report;
	end
endmodule
